// ### logic/pcd_pin_cell.sv
/*
  One pad's override resolver: merges peripheral overrides with the
  port data and direction bits, and gates the synchronised pad input.
  Assumes the pad input has already passed the two-flop synchroniser.
*/
`timescale 1ns/1ns
module pcd_pin_cell (
  // Overrides
  input wire logic pue,
  input wire logic puv,
  input wire logic dde,
  input wire logic ddv,
  input wire logic pve,
  input wire logic pvv,
  input wire logic diee,
  input wire logic diev,
  // Port register bits, system controls and synchronised pad input
  input wire logic portBit,
  input wire logic dirBit,
  input wire logic pullupDisable,
  input wire logic sleepInputDisable,
  input wire logic syncIn,
  // Pad side
  output logic pullupOut,
  output logic outEnable,
  output logic outValue,
  output logic inputEnable,
  output logic dataIn
);

  // ==========================================================
  // Resolution
  wire logic plainPullup = portBit & ~dirBit & ~pullupDisable;

  assign pullupOut = pue ? puv : plainPullup;
  assign outEnable = dde ? ddv : dirBit;
  assign outValue = pve ? pvv : portBit;
  assign inputEnable = diee ? diev : ~sleepInputDisable;
  assign dataIn = syncIn & inputEnable;

endmodule : pcd_pin_cell

// ### logic/pcd_pkg.sv
/*
  Constants for the upper/lower port alternate-function override block:
  register offsets, field positions, reset values and pin positions.
  Assumes a 32-bit APB master with byte addresses on an 8-bit bus.
*/
package pcd_pkg;

  // ==========================================================
  // Widths
  localparam int PCD_ADDR_W = 8;
  localparam int PCD_DATA_W = 32;
  localparam int PCD_PORT_W = 8;
  localparam int PCD_MASK_W = 3;
  localparam int PCD_PIN_N = 2 * PCD_PORT_W;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] PCD_OFS_UPPER_DATA = 8'h00;
  localparam logic [7:0] PCD_OFS_UPPER_DIR = 8'h04;
  localparam logic [7:0] PCD_OFS_UPPER_PIN = 8'h08;
  localparam logic [7:0] PCD_OFS_LOWER_DATA = 8'h0c;
  localparam logic [7:0] PCD_OFS_LOWER_DIR = 8'h10;
  localparam logic [7:0] PCD_OFS_LOWER_PIN = 8'h14;
  localparam logic [7:0] PCD_OFS_XMEM_CTRL = 8'h18;
  localparam logic [7:0] PCD_OFS_MISC_CTRL = 8'h1c;
  localparam logic [7:0] PCD_OFS_PC_MASK = 8'h20;

  // ==========================================================
  // Field positions
  localparam int PCD_XMEM_EN_BIT = 0;
  localparam int PCD_XMEM_SEL_LSB = 1;
  localparam int PCD_MISC_PIN_CHANGE_GROUP1_ENABLE_BIT = 0;
  localparam int PCD_MISC_ASYNC_BIT = 1;
  localparam int PCD_MISC_PUD_BIT = 2;

  // ==========================================================
  // Reset values
  localparam logic [7:0] PCD_PORT_RST = 8'h00;
  localparam logic [2:0] PCD_SEL_RST = 3'h0;
  localparam logic [31:0] PCD_RDATA_RST = 32'h0000_0000;

  // ==========================================================
  // Pin positions
  localparam int PCD_SCAN_LO = 4;
  localparam int PCD_TDO_PIN = 6;
  localparam int PCD_RD_PIN = 7;
  localparam int PCD_XOUT_PIN = 5;
  localparam int PCD_XIN_PIN = 4;
  localparam int PCD_IRQ1_PIN = 3;
  localparam int PCD_IRQ0_PIN = 2;
  localparam int PCD_TX_PIN = 1;
  localparam int PCD_RX_PIN = 0;

  // Upper port: address-bit ownership limit per pin (mask select below it)
  localparam logic [2:0] PCD_MASK_LIMIT [PCD_PORT_W] = '{
    0: 3'h7, 1: 3'h7, 2: 3'h6, 3: 3'h5,
    4: 3'h4, 5: 3'h3, 6: 3'h2, 7: 3'h1
  };

  // Lower port: constant direction and input-enable override values
  localparam logic [7:0] PCD_LOWER_DIRECTION_OVERRIDE_VALUE = 8'hc2;
  localparam logic [7:0] PCD_LOWER_INPUT_ENABLE_OVERRIDE_VALUE = 8'h0c;

endpackage : pcd_pkg

// ### logic/pcd_port_override.sv
/*
  Alternate-function override logic for the upper and lower 8-bit ports,
  with an APB register file for port data, direction and control bits.
  Assumes peripheral signals are on clk; pad inputs are asynchronous.
*/
// Our own choices: the APB interface to the registers and the register addresses.
// Behaviour
// - Upper pins 7..4 driven with address 15..12 when memory owns them and scan port is off
// - Upper pins 3..0 output address 11..8, pull-up off, when owned
// - Upper input enable forced by scan port (pins 7..4 only) or pin-change enable and mask
// - Synchronised upper inputs feed pin-change lines 8 to 15
// - Lower pins 7 and 6 carry memory read and write strobes
// - Timer async select frees lower pin 5 for crystal output
// - Timer async select frees lower pin 4 for crystal input
// - Lower pin 5 carries timer-1 compare-A waveform
// - Serial-0 clock on lower pin 4 synchronous only, direction picks way
// - Serial-1 clock on lower pin 2 synchronous only, direction picks way
// - Lower pin 3 feeds interrupt line 1 and timer-3 capture
// - Lower pin 2 feeds interrupt line 0
// - Serial-0 transmit forces lower pin 1 to drive transmit data
// - Scan data-out drives only in shift states, else pulled high
// - Scan pins keep pull-ups during reset while scan is enabled
// - Serial-0 receive forces lower pin 0 input; pull-up follows data
`timescale 1ns/1ns
module pcd_port_override (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pcd_pkg::PCD_ADDR_W-1:0] paddr,
  input wire logic [pcd_pkg::PCD_DATA_W-1:0] pwdata,
  output logic [pcd_pkg::PCD_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Upper port pads
  input wire logic [pcd_pkg::PCD_PORT_W-1:0] upperPadIn,
  output logic [pcd_pkg::PCD_PORT_W-1:0] upperPadPullup,
  output logic [pcd_pkg::PCD_PORT_W-1:0] upperPadOutEnable,
  output logic [pcd_pkg::PCD_PORT_W-1:0] upperPadOut,
  output logic [pcd_pkg::PCD_PORT_W-1:0] upperPadInputEnable,
  // Lower port pads
  input wire logic [pcd_pkg::PCD_PORT_W-1:0] lowerPadIn,
  output logic [pcd_pkg::PCD_PORT_W-1:0] lowerPadPullup,
  output logic [pcd_pkg::PCD_PORT_W-1:0] lowerPadOutEnable,
  output logic [pcd_pkg::PCD_PORT_W-1:0] lowerPadOut,
  output logic [pcd_pkg::PCD_PORT_W-1:0] lowerPadInputEnable,
  output logic timerXtalEnable,
  // System controls
  input wire logic scanPortEnable,
  input wire logic sleepInputDisable,
  // External memory
  input wire logic [pcd_pkg::PCD_PORT_W-1:0] extAddrHigh,
  input wire logic extReadStrobe,
  input wire logic extWriteStrobe,
  // Scan port
  input wire logic scanShiftInstructionState,
  input wire logic scanShiftDataState,
  input wire logic scanTdo,
  // Timers
  input wire logic timer1CompareAOut,
  input wire logic timer1CompareAEnable,
  input wire logic timer3CompareAOut,
  input wire logic timer3CompareAEnable,
  output logic timer3CaptureIn,
  // Serial ports
  input wire logic serial0SyncMode,
  input wire logic serial0TransmitEnable,
  input wire logic serial0TransmitData,
  input wire logic serial0ReceiveEnable,
  input wire logic serial0ClockOut,
  output logic serial0ClockIn,
  output logic serial0ReceiveIn,
  input wire logic serial1SyncMode,
  input wire logic serial1ClockOut,
  output logic serial1ClockIn,
  // Interrupt inputs
  input wire logic extIrq0Enable,
  input wire logic extIrq1Enable,
  output logic extIrqLine0,
  output logic extIrqLine1,
  output logic [15:8] pinChangeLine
);
  import pcd_pkg::*;

  // ==========================================================
  // Decode helpers
  function automatic logic addrHit(input logic [PCD_ADDR_W-1:0] a,
                                   input logic [7:0] ofs);
    return a == ofs;
  endfunction : addrHit

  function automatic logic maskBelow(input logic [PCD_MASK_W-1:0] sel,
                                     input logic [PCD_MASK_W-1:0] lim);
    return sel < lim;
  endfunction : maskBelow

  // ==========================================================
  // Registers
  logic [PCD_PORT_W-1:0] upperData_ff;
  logic [PCD_PORT_W-1:0] upperDir_ff;
  logic [PCD_PORT_W-1:0] lowerData_ff;
  logic [PCD_PORT_W-1:0] lowerDir_ff;
  logic [PCD_PORT_W-1:0] pinChangeMask_ff;
  logic extMemEnable_ff;
  logic [PCD_MASK_W-1:0] extMemHighMaskSelect_ff;
  logic pinChangeGroup1Enable_ff;
  logic timer2AsyncSelect_ff;
  logic pullupDisable_ff;
  logic [PCD_DATA_W-1:0] prdata_ff;
  logic [PCD_PIN_N-1:0] sync1_ff;
  logic [PCD_PIN_N-1:0] sync2_ff;

  // ==========================================================
  // APB decode
  wire logic setupPhase = psel & ~penable;
  wire logic accessPhase = psel & penable;
  wire logic writeEn = accessPhase & pwrite;
  wire logic hitUpperData = addrHit(paddr, PCD_OFS_UPPER_DATA);
  wire logic hitUpperDir = addrHit(paddr, PCD_OFS_UPPER_DIR);
  wire logic hitUpperPin = addrHit(paddr, PCD_OFS_UPPER_PIN);
  wire logic hitLowerData = addrHit(paddr, PCD_OFS_LOWER_DATA);
  wire logic hitLowerDir = addrHit(paddr, PCD_OFS_LOWER_DIR);
  wire logic hitLowerPin = addrHit(paddr, PCD_OFS_LOWER_PIN);
  wire logic hitXmem = addrHit(paddr, PCD_OFS_XMEM_CTRL);
  wire logic hitMisc = addrHit(paddr, PCD_OFS_MISC_CTRL);
  wire logic hitMask = addrHit(paddr, PCD_OFS_PC_MASK);
  wire logic hitAny = hitUpperData | hitUpperDir | hitUpperPin |
                      hitLowerData | hitLowerDir | hitLowerPin |
                      hitXmem | hitMisc | hitMask;
  wire logic [PCD_PORT_W-1:0] wByte = pwdata[PCD_PORT_W-1:0];

  assign pready = 1'b1;
  assign pslverr = accessPhase & ~hitAny;
  assign prdata = prdata_ff;

  // Next values
  wire logic [PCD_PORT_W-1:0] nxt_upperData =
    (writeEn & hitUpperData) ? wByte : upperData_ff;
  wire logic [PCD_PORT_W-1:0] nxt_upperDir =
    (writeEn & hitUpperDir) ? wByte : upperDir_ff;
  wire logic [PCD_PORT_W-1:0] nxt_lowerData =
    (writeEn & hitLowerData) ? wByte : lowerData_ff;
  wire logic [PCD_PORT_W-1:0] nxt_lowerDir =
    (writeEn & hitLowerDir) ? wByte : lowerDir_ff;
  wire logic [PCD_PORT_W-1:0] nxt_pinChangeMask =
    (writeEn & hitMask) ? wByte : pinChangeMask_ff;
  wire logic nxt_extMemEnable =
    (writeEn & hitXmem) ? pwdata[PCD_XMEM_EN_BIT] : extMemEnable_ff;
  wire logic [PCD_MASK_W-1:0] nxt_extMemHighMaskSelect =
    (writeEn & hitXmem) ?
    pwdata[PCD_XMEM_SEL_LSB +: PCD_MASK_W] : extMemHighMaskSelect_ff;
  wire logic nxt_pinChangeGroup1Enable = (writeEn & hitMisc) ?
    pwdata[PCD_MISC_PIN_CHANGE_GROUP1_ENABLE_BIT] : pinChangeGroup1Enable_ff;
  wire logic nxt_timer2AsyncSelect = (writeEn & hitMisc) ?
    pwdata[PCD_MISC_ASYNC_BIT] : timer2AsyncSelect_ff;
  wire logic nxt_pullupDisable = (writeEn & hitMisc) ?
    pwdata[PCD_MISC_PUD_BIT] : pullupDisable_ff;

  // ==========================================================
  // Override vectors, upper port in low half, lower port in high half
  logic [PCD_PIN_N-1:0] pue, puv, dde, ddv, pve, pvv, diee, diev;
  logic [PCD_PIN_N-1:0] pinPullup, pinOutEn, pinOut, pinInEn, pinIn;
  logic [PCD_PORT_W-1:0] upperIn, lowerIn;
  wire logic tdoDrive = scanShiftInstructionState | scanShiftDataState;
  wire logic async = timer2AsyncSelect_ff;
  wire logic serial0ClkOutEn = serial0SyncMode & lowerDir_ff[PCD_XIN_PIN];
  wire logic serial1ClkOutEn = serial1SyncMode & lowerDir_ff[PCD_IRQ0_PIN];

  genvar i;
  generate
    for (i = 0; i < PCD_PORT_W; i++) begin : gUpper
      wire logic memOwns = extMemEnable_ff &
        maskBelow(extMemHighMaskSelect_ff, PCD_MASK_LIMIT[i]);
      wire logic pcSel = pinChangeGroup1Enable_ff & pinChangeMask_ff[i];
      if (i >= PCD_SCAN_LO) begin : gScan
        assign pue[i] = memOwns | scanPortEnable;
        assign puv[i] = scanPortEnable;
        assign dde[i] = memOwns | scanPortEnable;
        assign ddv[i] = scanPortEnable ?
          ((i == PCD_TDO_PIN) ? tdoDrive : 1'b0) : 1'b1;
        assign pve[i] = memOwns |
          ((i == PCD_TDO_PIN) ? scanPortEnable : 1'b0);
        assign pvv[i] = ((i == PCD_TDO_PIN) && scanPortEnable) ?
          scanTdo : extAddrHigh[i];
        assign diee[i] = scanPortEnable | pcSel;
        assign diev[i] = scanPortEnable;
      end else begin : gAddr
        // forced output of low address bits
        assign pue[i] = memOwns;
        assign puv[i] = 1'b0;
        assign dde[i] = memOwns;
        assign ddv[i] = 1'b1;
        assign pve[i] = memOwns;
        assign pvv[i] = extAddrHigh[i];
        assign diee[i] = pcSel;
        assign diev[i] = 1'b1;
      end
    end
  endgenerate

  // Lower port, bits ordered 7 down to 0
  // memory strobes, crystal release, serial-0
  assign pue[PCD_PIN_N-1:PCD_PORT_W] = {extMemEnable_ff, extMemEnable_ff,
    async, async, 1'b0, 1'b0, serial0TransmitEnable, serial0ReceiveEnable};
  // receive pull-up still follows data bit
  assign puv[PCD_PIN_N-1:PCD_PORT_W] = {7'h00,
    lowerData_ff[PCD_RX_PIN] & ~pullupDisable_ff};
  assign dde[PCD_PIN_N-1:PCD_PORT_W] = pue[PCD_PIN_N-1:PCD_PORT_W];
  assign ddv[PCD_PIN_N-1:PCD_PORT_W] = PCD_LOWER_DIRECTION_OVERRIDE_VALUE;
  assign pve[PCD_PIN_N-1:PCD_PORT_W] = {extMemEnable_ff, extMemEnable_ff,
    timer1CompareAEnable, serial0ClkOutEn | timer3CompareAEnable, 1'b0,
    serial1ClkOutEn, serial0TransmitEnable, 1'b0};
  assign pvv[PCD_PIN_N-1:PCD_PORT_W] = {extReadStrobe, extWriteStrobe,
    timer1CompareAOut,
    serial0ClkOutEn ? serial0ClockOut : timer3CompareAOut, 1'b0,
    serial1ClockOut, serial0TransmitData, 1'b0};
  // interrupt pins keep their inputs enabled
  assign diee[PCD_PIN_N-1:PCD_PORT_W] = {2'h0, async, async,
    extIrq1Enable, extIrq0Enable, 2'h0};
  assign diev[PCD_PIN_N-1:PCD_PORT_W] = PCD_LOWER_INPUT_ENABLE_OVERRIDE_VALUE;

  wire logic [PCD_PIN_N-1:0] portBits = {lowerData_ff, upperData_ff};
  wire logic [PCD_PIN_N-1:0] dirBits = {lowerDir_ff, upperDir_ff};

  // ==========================================================
  // Pin cells
  generate
    for (i = 0; i < PCD_PIN_N; i++) begin : gCell
      pcd_pin_cell uCell (
        .pue(pue[i]),
        .puv(puv[i]),
        .dde(dde[i]),
        .ddv(ddv[i]),
        .pve(pve[i]),
        .pvv(pvv[i]),
        .diee(diee[i]),
        .diev(diev[i]),
        .portBit(portBits[i]),
        .dirBit(dirBits[i]),
        .pullupDisable(pullupDisable_ff),
        .sleepInputDisable(sleepInputDisable),
        .syncIn(sync2_ff[i]),
        .pullupOut(pinPullup[i]),
        .outEnable(pinOutEn[i]),
        .outValue(pinOut[i]),
        .inputEnable(pinInEn[i]),
        .dataIn(pinIn[i])
      );
    end
  endgenerate

  assign upperPadPullup = pinPullup[PCD_PORT_W-1:0];
  assign upperPadOutEnable = pinOutEn[PCD_PORT_W-1:0];
  assign upperPadOut = pinOut[PCD_PORT_W-1:0];
  assign upperPadInputEnable = pinInEn[PCD_PORT_W-1:0];
  assign lowerPadPullup = pinPullup[PCD_PIN_N-1:PCD_PORT_W];
  assign lowerPadOutEnable = pinOutEn[PCD_PIN_N-1:PCD_PORT_W];
  assign lowerPadOut = pinOut[PCD_PIN_N-1:PCD_PORT_W];
  assign lowerPadInputEnable = pinInEn[PCD_PIN_N-1:PCD_PORT_W];
  assign upperIn = pinIn[PCD_PORT_W-1:0];
  assign lowerIn = pinIn[PCD_PIN_N-1:PCD_PORT_W];

  // ==========================================================
  // Input routing
  // pin-change lines from synchronised inputs
  assign pinChangeLine = upperIn;
  // interrupt 1 and capture share pin 3
  assign extIrqLine1 = lowerIn[PCD_IRQ1_PIN];
  assign timer3CaptureIn = lowerIn[PCD_IRQ1_PIN];
  assign extIrqLine0 = lowerIn[PCD_IRQ0_PIN];
  assign serial0ReceiveIn = lowerIn[PCD_RX_PIN];
  // clock input only in synchronous mode with direction clear
  assign serial0ClockIn = serial0SyncMode & ~lowerDir_ff[PCD_XIN_PIN] &
                          lowerIn[PCD_XIN_PIN];
  // clock input only in synchronous mode with direction clear
  assign serial1ClockIn = serial1SyncMode & ~lowerDir_ff[PCD_IRQ0_PIN] &
                          lowerIn[PCD_IRQ0_PIN];
  // oscillator amplifier takes both crystal pins
  assign timerXtalEnable = async;

  // ==========================================================
  // Read mux, captured in the setup cycle
  wire logic [PCD_PORT_W-1:0] miscByte = {5'h00, pullupDisable_ff,
    timer2AsyncSelect_ff, pinChangeGroup1Enable_ff};
  wire logic [PCD_PORT_W-1:0] xmemByte = {4'h0, extMemHighMaskSelect_ff,
    extMemEnable_ff};
  wire logic [PCD_PORT_W-1:0] readByte =
    hitUpperData ? upperData_ff :
    hitUpperDir ? upperDir_ff :
    hitUpperPin ? upperIn :
    hitLowerData ? lowerData_ff :
    hitLowerDir ? lowerDir_ff :
    hitLowerPin ? lowerIn :
    hitXmem ? xmemByte :
    hitMisc ? miscByte :
    hitMask ? pinChangeMask_ff : PCD_PORT_RST;
  wire logic [PCD_DATA_W-1:0] nxt_prdata = setupPhase ?
    {{(PCD_DATA_W-PCD_PORT_W){1'b0}}, readByte} : prdata_ff;

  // ==========================================================
  // Flip-flops
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      upperData_ff <= PCD_PORT_RST;
      upperDir_ff <= PCD_PORT_RST;
      lowerData_ff <= PCD_PORT_RST;
      lowerDir_ff <= PCD_PORT_RST;
      pinChangeMask_ff <= PCD_PORT_RST;
    end else begin
      upperData_ff <= nxt_upperData;
      upperDir_ff <= nxt_upperDir;
      lowerData_ff <= nxt_lowerData;
      lowerDir_ff <= nxt_lowerDir;
      pinChangeMask_ff <= nxt_pinChangeMask;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      extMemEnable_ff <= 1'b0;
      extMemHighMaskSelect_ff <= PCD_SEL_RST;
      pinChangeGroup1Enable_ff <= 1'b0;
      timer2AsyncSelect_ff <= 1'b0;
      pullupDisable_ff <= 1'b0;
      prdata_ff <= PCD_RDATA_RST;
    end else begin
      extMemEnable_ff <= nxt_extMemEnable;
      extMemHighMaskSelect_ff <= nxt_extMemHighMaskSelect;
      pinChangeGroup1Enable_ff <= nxt_pinChangeGroup1Enable;
      timer2AsyncSelect_ff <= nxt_timer2AsyncSelect;
      pullupDisable_ff <= nxt_pullupDisable;
      prdata_ff <= nxt_prdata;
    end
  end

  // Pad synchroniser, first stage read only by second
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1_ff <= {PCD_PIN_N{1'b0}};
      sync2_ff <= {PCD_PIN_N{1'b0}};
    end else begin
      sync1_ff <= {lowerPadIn, upperPadIn};
      sync2_ff <= sync1_ff;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence sDirSetup;
    psel && !penable && pwrite && paddr == PCD_OFS_LOWER_DIR;
  endsequence
  sequence sDirAccess;
    psel && penable && pwrite && paddr == PCD_OFS_LOWER_DIR;
  endsequence

  a_addr_high_drive: assert property (
    extMemEnable_ff && extMemHighMaskSelect_ff < 3'h1 && !scanPortEnable
    |-> upperPadOutEnable[7] && upperPadOut[7] == extAddrHigh[7]
        && !upperPadPullup[7])
    else $error("upper pin 7 not driving address");
  a_addr_low_drive: assert property (
    extMemEnable_ff && extMemHighMaskSelect_ff == 3'h4
    |-> upperPadOutEnable[3:0] == 4'hf && upperPadOut[3:0] ==
        extAddrHigh[3:0] && upperPadPullup[3:0] == 4'h0)
    else $error("low address pins not owned by memory");
  a_input_override: assert property (
    !scanPortEnable && pinChangeGroup1Enable_ff && pinChangeMask_ff[2]
    |-> upperPadInputEnable[2])
    else $error("pin-change input not enabled");
  a_pin_change_route: assert property (
    $past(rst_n, 2) && upperPadInputEnable[5]
    |-> pinChangeLine[13] == $past(upperPadIn[5], 2))
    else $error("pin-change line 13 mismatch");
  a_strobe_route: assert property (
    extMemEnable_ff |-> lowerPadOutEnable[7:6] == 2'h3 &&
    lowerPadOut[7:6] == {extReadStrobe, extWriteStrobe})
    else $error("memory strobes not on lower pins");
  a_xtal_release: assert property (
    timer2AsyncSelect_ff |-> lowerPadOutEnable[5:4] == 2'h0 &&
    lowerPadPullup[5:4] == 2'h0 && lowerPadInputEnable[5:4] == 2'h0
    && timerXtalEnable)
    else $error("crystal pins still tied to port");
  a_compare_out: assert property (
    timer1CompareAEnable |-> lowerPadOut[5] == timer1CompareAOut)
    else $error("compare-A not on lower pin 5");
  a_serial_clock: assert property (
    !serial0SyncMode |-> !serial0ClockIn &&
    (timer3CompareAEnable || lowerPadOut[4] == lowerData_ff[4]))
    else $error("serial-0 clock active outside sync mode");
  a_tx_force: assert property (
    serial0TransmitEnable |-> lowerPadOutEnable[1] &&
    lowerPadOut[1] == serial0TransmitData)
    else $error("transmit pin not forced");
  a_tdo_drive: assert property (
    scanPortEnable |-> upperPadOutEnable[6] == tdoDrive &&
    upperPadPullup[6])
    else $error("data-out drive outside shift states");
  a_scan_pullup: assert property (
    @(posedge clk) disable iff (1'b0)
    scanPortEnable |-> upperPadPullup[7] && upperPadPullup[5] &&
    upperPadPullup[4])
    else $error("scan pull-ups dropped");
  a_rx_force: assert property (
    serial0ReceiveEnable |-> !lowerPadOutEnable[0] &&
    lowerPadPullup[0] == (lowerData_ff[0] && !pullupDisable_ff))
    else $error("receive pin not forced input");
  a_dir_write: assert property (
    sDirSetup ##1 sDirAccess ##1 !timer2AsyncSelect_ff
    |-> lowerPadOutEnable[5] == $past(pwdata[5]))
    else $error("direction write not seen on pad");

endmodule : pcd_port_override

// ### testbench/pcd_pad_model.sv
/*
  Pad wire model: resolves each pad level from drive, pull-up and source.
  Assumes the outside source is driven by the bench.
*/
`timescale 1ns/1ns
module pcd_pad_model (
  // Pad controls
  input wire logic [7:0] oe,
  input wire logic [7:0] out,
  input wire logic [7:0] pu,
  // Outside source and level
  input wire logic [7:0] ext,
  output logic [7:0] level
);
  // Drive wins, then pull-up, then the outside source
  assign level = (oe & out) | (~oe & pu) | (~oe & ~pu & ext);
endmodule : pcd_pad_model

// ### testbench/tb_top.sv
/*
  Bench for the port override block: APB master, pad models, scenarios.
  Assumes zero-wait APB; a watchdog ends any hang.
*/
`timescale 1ns/1ns
module tb_top;
  import pcd_pkg::*;
  logic clk, rst_n, psel, penable, pwrite, scanPortEnable, sleepInputDisable;
  logic extReadStrobe, extWriteStrobe, scanShiftInstructionState, scanTdo;
  logic scanShiftDataState, timer1CompareAOut, timer1CompareAEnable, serr;
  logic timer3CompareAOut, timer3CompareAEnable, serial0SyncMode;
  logic serial0TransmitEnable, serial0TransmitData, serial0ReceiveEnable;
  logic serial0ClockOut, serial1SyncMode, serial1ClockOut, timerXtalEnable;
  logic extIrq0Enable, extIrq1Enable, pready, pslverr, timer3CaptureIn;
  logic serial0ClockIn, serial0ReceiveIn, serial1ClockIn;
  logic extIrqLine0, extIrqLine1;
  logic [7:0] paddr, upperPadIn, lowerPadIn, extAddrHigh, upExt, loExt;
  logic [7:0] upperPadPullup, upperPadOutEnable, upperPadOut;
  logic [7:0] upperPadInputEnable, lowerPadPullup, lowerPadOutEnable;
  logic [7:0] lowerPadOut, lowerPadInputEnable;
  logic [15:8] pinChangeLine;
  logic [31:0] pwdata, prdata, rdat;
  int nErrors = 0;
  int comparisons = 0;

  pcd_port_override dut_u (.clk, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .upperPadIn, .upperPadPullup,
    .upperPadOutEnable, .upperPadOut, .upperPadInputEnable, .lowerPadIn,
    .lowerPadPullup, .lowerPadOutEnable, .lowerPadOut, .lowerPadInputEnable,
    .timerXtalEnable, .scanPortEnable, .sleepInputDisable, .extAddrHigh,
    .extReadStrobe, .extWriteStrobe, .scanShiftInstructionState,
    .scanShiftDataState, .scanTdo, .timer1CompareAOut, .timer1CompareAEnable,
    .timer3CompareAOut, .timer3CompareAEnable, .timer3CaptureIn,
    .serial0SyncMode, .serial0TransmitEnable, .serial0TransmitData,
    .serial0ReceiveEnable, .serial0ClockOut, .serial0ClockIn,
    .serial0ReceiveIn, .serial1SyncMode, .serial1ClockOut, .serial1ClockIn,
    .extIrq0Enable, .extIrq1Enable, .extIrqLine0, .extIrqLine1,
    .pinChangeLine);
  pcd_pad_model up_u (.oe(upperPadOutEnable), .out(upperPadOut),
    .pu(upperPadPullup), .ext(upExt), .level(upperPadIn));
  pcd_pad_model lo_u (.oe(lowerPadOutEnable), .out(lowerPadOut),
    .pu(lowerPadPullup), .ext(loExt), .level(lowerPadIn));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("comparisons %0d errors %0d", comparisons, nErrors);
    if (nErrors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [7:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      nErrors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic t_upper();
    logic [7:0] own;
    @(posedge clk);
    upExt <= 8'h5a;
    repeat (3) @(posedge clk);
    chk("pin change lines", 8'h5a, pinChangeLine);
    apb(PCD_OFS_MISC_CTRL, 1'b1, 8'h01);
    apb(PCD_OFS_PC_MASK, 1'b1, 8'h3c);
    sleepInputDisable <= 1'b1;
    @(negedge clk);
    chk("input enable", 8'h0c, upperPadInputEnable);
    apb(PCD_OFS_UPPER_DATA, 1'b1, 8'hff);
    extAddrHigh <= 8'ha5;
    for (int k = 0; k < 9; k++) begin
      for (int i = 0; i < 8; i++)
        own[i] = k < ((i == 0) ? 7 : 8 - i);
      apb(PCD_OFS_XMEM_CTRL, 1'b1, (k < 8) ? 8'(2 * k + 1) : 8'h00);
      @(negedge clk);
      chk("upper drive", own, upperPadOutEnable);
      chk("upper value", (own & 8'ha5) | ~own, upperPadOut);
      chk("upper pullup", ~own, upperPadPullup);
    end
  endtask : t_upper

  task automatic t_scan();
    for (int s = 0; s < 4; s++) begin
      @(posedge clk);
      scanPortEnable <= 1'b1;
      {scanShiftInstructionState, scanShiftDataState} <= 2'(s);
      scanTdo <= s[0];
      @(negedge clk);
      chk("data-out pin", {5'h00, s != 0, 1'b1, s == 1 || s == 3},
        {5'h00, upperPadOutEnable[6], upperPadPullup[6], upperPadOut[6]
        & upperPadOutEnable[6]});
    end
    chk("scan input enable", 8'hf0, upperPadInputEnable & 8'hf0);
    @(posedge clk);
    scanPortEnable <= 1'b0;
  endtask : t_scan

  task automatic t_lower();
    apb(PCD_OFS_XMEM_CTRL, 1'b1, 8'h01);
    extReadStrobe <= 1'b1;
    @(negedge clk);
    chk("strobes", 8'h0e, {4'h0, lowerPadOutEnable[7:6],
      lowerPadOut[7:6]});
    apb(PCD_OFS_XMEM_CTRL, 1'b1, 8'h00);
    apb(PCD_OFS_LOWER_DATA, 1'b1, 8'h01);
    apb(PCD_OFS_LOWER_DIR, 1'b1, 8'h31);
    {serial0TransmitEnable, serial0TransmitData, serial0ReceiveEnable} <= 3'h7;
    {timer1CompareAEnable, timer1CompareAOut, serial0SyncMode} <= 3'h7;
    {serial0ClockOut, timer3CompareAEnable} <= 2'h3;
    @(negedge clk);
    chk("low drive", 8'h32, lowerPadOutEnable & 8'h33);
    chk("low value", 8'h32, lowerPadOut & 8'h32);
    chk("rx pullup", 8'h01, lowerPadPullup & 8'h01);
    @(posedge clk);
    serial0SyncMode <= 1'b0;
    @(negedge clk);
    chk("compare value", 8'h00, lowerPadOut & 8'h10);
    apb(PCD_OFS_MISC_CTRL, 1'b1, 8'h03);
    {extIrq0Enable, extIrq1Enable, serial1SyncMode} <= 3'h7;
    sleepInputDisable <= 1'b0;
    loExt <= 8'h0c;
    @(negedge clk);
    chk("xtal pins", 8'h01, {5'h00, |lowerPadOutEnable[5:4],
      |lowerPadInputEnable[5:4], timerXtalEnable});
    repeat (3) @(posedge clk);
    chk("irq inputs", 8'h1f, {3'h0, serial0ReceiveIn, extIrqLine1,
      timer3CaptureIn, extIrqLine0, serial1ClockIn});
    apb(PCD_OFS_LOWER_DIR, 1'b0, 8'h00);
    chk("dir readback", 8'h31, rdat[7:0]);
    apb(PCD_OFS_MISC_CTRL, 1'b1, 8'h07);
    @(negedge clk);
    chk("rx pullup off", 8'h00, lowerPadPullup & 8'h01);
    apb(8'hfc, 1'b0, 8'h00);
    chk("unmapped", 8'h01, {rdat[6:0], serr});
  endtask : t_lower

  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, extAddrHigh, upExt} = '0;
    {loExt, sleepInputDisable, extReadStrobe, extWriteStrobe, scanTdo} = '0;
    {scanShiftInstructionState, scanShiftDataState, timer1CompareAOut} = '0;
    {timer1CompareAEnable, timer3CompareAOut, timer3CompareAEnable} = '0;
    {serial0SyncMode, serial0TransmitEnable, serial0TransmitData} = '0;
    {serial0ReceiveEnable, serial0ClockOut, serial1SyncMode} = '0;
    {serial1ClockOut, extIrq0Enable, extIrq1Enable} = '0;
    scanPortEnable = 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("scan pullups", 8'hb0, upperPadPullup & 8'hb0);
    @(posedge clk);
    rst_n <= 1'b1;
    scanPortEnable <= 1'b0;
    t_upper();
    t_scan();
    t_lower();
    report_and_stop();
  end

  initial begin
    #20000;
    nErrors++;
    report_and_stop();
  end
endmodule : tb_top
